//--- pkg/wtb_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef WTB_DEFS_SVH
`define WTB_DEFS_SVH

`define WTB_ADDR_W 8
`define WTB_OFS_IRQ_CLR 8'h24
`define WTB_OFS_IRQ_SET 8'h28
`define WTB_OFS_STAGED 8'h68

`define WTB_IRQ_WRAP_BIT 0
`define WTB_IRQ_RESTART_BIT 1
`define WTB_IRQ_COUNTER_BIT 2
`define WTB_IRQ_ERROR_BIT 3
`define WTB_IRQ_HALTED_BIT 11
`define WTB_IRQ_MASK 32'h0000080F
`define WTB_IRQ_RESET 32'h00000000

`define WTB_SWAP_LSB 24
`define WTB_SWAP_MSB 27
`define WTB_POL_LSB 16
`define WTB_POL_MSB 19
`define WTB_CICC_LSB 8
`define WTB_CICC_MSB 11
`define WTB_CIPER_BIT 7
`define WTB_RAMP_LSB 4
`define WTB_RAMP_MSB 5
`define WTB_SHAPE_LSB 0
`define WTB_SHAPE_MSB 2
`define WTB_STAGED_MASK 32'h0F0F0FB7
`define WTB_STAGED_RESET 32'h00000000

`define WTB_SYNC_STAGES 2
`define WTB_WO_NUM 8

`endif

//--- pkg/wtb_pkg.sv
// Types shared by the waveform buffer block
package wtb_pkg;

	typedef struct packed {
		logic [3:0] pair_exchange;
		logic [3:0] output_inversion;
		logic [3:0] circular_compare;
		logic circular_top;
		logic [1:0] ramp;
		logic [2:0] shape_select;
	} wtb_wave_cfg_t;

	typedef struct packed {
		logic halted_fault;
		logic error;
		logic counter;
		logic restart;
		logic wraparound;
	} wtb_irq_vec_t;

	typedef struct packed {
		logic sel;
		logic write;
		logic read;
		logic [7:0] addr;
		logic [31:0] wdata;
	} wtb_bus_req_t;

	typedef enum logic [1:0] {
		WTB_SYNC_IDLE,
		WTB_SYNC_BUSY,
		WTB_SYNC_DONE
	} wtb_sync_state_t;

endpackage : wtb_pkg

//--- logic/wtb_write_sync.sv
// Delays a register write by a fixed number of core cycles before it takes effect
`timescale 1ns/1ps
`include "wtb_defs.svh"
module wtb_write_sync #(
	parameter int WIDTH = 32,
	parameter int STAGES = `WTB_SYNC_STAGES
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic [WIDTH-1:0] data_in,
	output logic busy,
	output logic done,
	output logic [WIDTH-1:0] data_out
);

	wtb_pkg::wtb_sync_state_t state_ff;
	logic [7:0] count_ff;
	logic [WIDTH-1:0] data_ff;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= wtb_pkg::WTB_SYNC_IDLE;
			count_ff <= 8'h00;
			data_ff <= '0;
		end else begin
			case (state_ff)
				wtb_pkg::WTB_SYNC_IDLE: begin
					if (start) begin
						state_ff <= wtb_pkg::WTB_SYNC_BUSY;
						count_ff <= 8'(STAGES - 1);
						data_ff <= data_in;
					end
				end
				wtb_pkg::WTB_SYNC_BUSY: begin
					if (count_ff == 8'h00) begin
						state_ff <= wtb_pkg::WTB_SYNC_DONE;
					end else begin
						count_ff <= count_ff - 8'h01;
					end
				end
				wtb_pkg::WTB_SYNC_DONE: begin
					state_ff <= wtb_pkg::WTB_SYNC_IDLE;
				end
				default: begin
					state_ff <= wtb_pkg::WTB_SYNC_IDLE;
				end
			endcase
		end
	end

	assign busy = (state_ff != wtb_pkg::WTB_SYNC_IDLE);
	assign done = (state_ff == wtb_pkg::WTB_SYNC_DONE);
	assign data_out = data_ff;

endmodule : wtb_write_sync

//--- logic/wtb_waveform_buffer.sv
// Staged waveform configuration, interrupt enables and waveform output stage
//
// Functional notes
// - Clear register: one clears enable, zero ignored
// - Enable bits at 0,1,2,3 and 11
// - Set register enables; clear register reads same
// - Staged pair swap bits 27:24, copied on update
// - Staged polarity bits 19:16, copied on update
// - Staged circular compare bits 11:8, copied on update
// - Staged circular period bit 7, copied on update
// - Staged ramp field 5:4, copied on update
// - Staged shape field 2:0, copied on update
// - Keeps running in sleep; irq wakes system
// - Staged register writes synchronized before taking effect; enable set/clear writes act at once
// - Bus clock enabled after reset by default
// - One dedicated waveform output per channel
// - Presents one DMA request line to controller
`timescale 1ns/1ps
`include "wtb_defs.svh"
module wtb_waveform_buffer #(
	parameter int WO_NUM = `WTB_WO_NUM,
	parameter int SYNC_STAGES = `WTB_SYNC_STAGES
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic bus_sel,
	input wire logic bus_write,
	input wire logic bus_read,
	input wire logic [7:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	output logic [31:0] bus_rdata_ff,
	output logic bus_ready_ff,
	output logic bus_error_ff,
	input wire logic double_buffer_en,
	input wire logic update_cond,
	input wire logic [4:0] irq_events,
	input wire logic [WO_NUM-1:0] compare_level,
	input wire logic dma_ack,
	output logic [WO_NUM-1:0] waveform_out_ff,
	output logic irq_req_ff,
	output logic dma_req_ff,
	output logic update_event_ff,
	output logic staged_valid_ff,
	output logic sync_busy_ff,
	output logic [3:0] pair_exchange_live_ff,
	output logic [3:0] output_inversion_live_ff,
	output logic [3:0] circular_compare_live_ff,
	output logic circular_top_live_ff,
	output logic [1:0] ramp_live_ff,
	output logic [2:0] shape_select_live_ff
);

	localparam int HALF = WO_NUM / 2;

	wtb_pkg::wtb_bus_req_t req;
	wtb_pkg::wtb_irq_vec_t irq_enable_ff;
	wtb_pkg::wtb_irq_vec_t irq_pending;
	wtb_pkg::wtb_wave_cfg_t live_cfg;
	wtb_pkg::wtb_wave_cfg_t commit_cfg;

	logic [31:0] staged_waveform_config_ff;
	logic [31:0] committed_ff;
	logic [31:0] irq_enable_word;
	logic [31:0] nxt_rdata;
	logic nxt_error;
	logic hit_clr;
	logic hit_set;
	logic hit_staged;
	logic take;
	logic take_wr;
	logic take_rd;
	logic sync_start;
	logic sync_busy;
	logic sync_done;
	logic [31:0] sync_data;
	logic apply_update;
	logic [WO_NUM-1:0] level_with_pol;
	logic [WO_NUM-1:0] nxt_wave;

	assign req.sel = bus_sel;
	assign req.write = bus_write;
	assign req.read = bus_read;
	assign req.addr = bus_addr;
	assign req.wdata = bus_wdata;

	assign hit_clr = (req.addr == `WTB_OFS_IRQ_CLR);
	assign hit_set = (req.addr == `WTB_OFS_IRQ_SET);
	assign hit_staged = (req.addr == `WTB_OFS_STAGED);

	// A staged write waits while the previous one is still crossing,
	// so no write is ever lost; the bus simply sees a later ready.
	assign take = req.sel & (req.write | req.read) & ~bus_ready_ff
		& ~(hit_staged & req.write & sync_busy);
	assign take_wr = take & req.write;
	assign take_rd = take & req.read & ~req.write;
	assign sync_start = take_wr & hit_staged;

	// Bus side needs no clock enable of its own: it runs from reset on
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			bus_ready_ff <= 1'b0;
			bus_error_ff <= 1'b0;
			bus_rdata_ff <= 32'h00000000;
		end else begin
			bus_ready_ff <= take;
			bus_error_ff <= take & nxt_error;
			if (take_rd) begin
				bus_rdata_ff <= nxt_rdata;
			end else if (take) begin
				bus_rdata_ff <= 32'h00000000;
			end
		end
	end

	// Both enable views share one storage word
	assign irq_enable_word = {20'h00000, irq_enable_ff.halted_fault, 7'h00,
		irq_enable_ff.error, irq_enable_ff.counter,
		irq_enable_ff.restart, irq_enable_ff.wraparound};

	always_comb begin
		nxt_rdata = 32'h00000000;
		nxt_error = 1'b0;
		if (hit_clr || hit_set) begin
			nxt_rdata = irq_enable_word;
		end else if (hit_staged) begin
			nxt_rdata = staged_waveform_config_ff & `WTB_STAGED_MASK;
		end else begin
			nxt_error = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_enable_ff <= '0;
		end else if (take_wr && hit_clr) begin
			if (req.wdata[`WTB_IRQ_WRAP_BIT]) irq_enable_ff.wraparound <= 1'b0;
			if (req.wdata[`WTB_IRQ_RESTART_BIT]) irq_enable_ff.restart <= 1'b0;
			if (req.wdata[`WTB_IRQ_COUNTER_BIT]) irq_enable_ff.counter <= 1'b0;
			if (req.wdata[`WTB_IRQ_ERROR_BIT]) irq_enable_ff.error <= 1'b0;
			if (req.wdata[`WTB_IRQ_HALTED_BIT]) irq_enable_ff.halted_fault <= 1'b0;
		end else if (take_wr && hit_set) begin
			if (req.wdata[`WTB_IRQ_WRAP_BIT]) irq_enable_ff.wraparound <= 1'b1;
			if (req.wdata[`WTB_IRQ_RESTART_BIT]) irq_enable_ff.restart <= 1'b1;
			if (req.wdata[`WTB_IRQ_COUNTER_BIT]) irq_enable_ff.counter <= 1'b1;
			if (req.wdata[`WTB_IRQ_ERROR_BIT]) irq_enable_ff.error <= 1'b1;
			if (req.wdata[`WTB_IRQ_HALTED_BIT]) irq_enable_ff.halted_fault <= 1'b1;
		end
	end

	// Request is a plain level so it can wake the system with no clock
	// gating here; the block itself is never stopped by sleep.
	assign irq_pending = irq_events & irq_enable_ff;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_req_ff <= 1'b0;
		end else begin
			irq_req_ff <= |irq_pending;
		end
	end

	// Software view of the staged word updates at once for read-back
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			staged_waveform_config_ff <= `WTB_STAGED_RESET;
		end else if (sync_start) begin
			staged_waveform_config_ff <= req.wdata & `WTB_STAGED_MASK;
		end
	end

	wtb_write_sync #(
		.WIDTH(32),
		.STAGES(SYNC_STAGES)
	) u_sync (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.start(sync_start),
		.data_in(req.wdata & `WTB_STAGED_MASK),
		.busy(sync_busy),
		.done(sync_done),
		.data_out(sync_data)
	);

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sync_busy_ff <= 1'b0;
		end else begin
			sync_busy_ff <= sync_start | (sync_busy & ~sync_done);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			committed_ff <= `WTB_STAGED_RESET;
		end else if (sync_done) begin
			committed_ff <= sync_data;
		end
	end

	assign commit_cfg.pair_exchange = committed_ff[`WTB_SWAP_MSB:`WTB_SWAP_LSB];
	assign commit_cfg.output_inversion = committed_ff[`WTB_POL_MSB:`WTB_POL_LSB];
	assign commit_cfg.circular_compare = committed_ff[`WTB_CICC_MSB:`WTB_CICC_LSB];
	assign commit_cfg.circular_top = committed_ff[`WTB_CIPER_BIT];
	assign commit_cfg.ramp = committed_ff[`WTB_RAMP_MSB:`WTB_RAMP_LSB];
	assign commit_cfg.shape_select = committed_ff[`WTB_SHAPE_MSB:`WTB_SHAPE_LSB];

	// Only content that has arrived and not yet been consumed is copied
	assign apply_update = double_buffer_en & update_cond & staged_valid_ff;

	// A fresh commit in the update cycle keeps the flag set
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			staged_valid_ff <= 1'b0;
		end else if (sync_done && double_buffer_en) begin
			staged_valid_ff <= 1'b1;
		end else if (apply_update || !double_buffer_en) begin
			staged_valid_ff <= 1'b0;
		end
	end

	// Without double buffering a synchronized write goes straight live
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			live_cfg <= '0;
		end else if (apply_update) begin
			live_cfg.pair_exchange <= commit_cfg.pair_exchange;
			live_cfg.output_inversion <= commit_cfg.output_inversion;
			live_cfg.circular_compare <= commit_cfg.circular_compare;
			live_cfg.circular_top <= commit_cfg.circular_top;
			live_cfg.ramp <= commit_cfg.ramp;
			live_cfg.shape_select <= commit_cfg.shape_select;
		end else if (sync_done && !double_buffer_en) begin
			live_cfg <= wtb_pkg::wtb_wave_cfg_t'({sync_data[`WTB_SWAP_MSB:`WTB_SWAP_LSB],
				sync_data[`WTB_POL_MSB:`WTB_POL_LSB],
				sync_data[`WTB_CICC_MSB:`WTB_CICC_LSB],
				sync_data[`WTB_CIPER_BIT],
				sync_data[`WTB_RAMP_MSB:`WTB_RAMP_LSB],
				sync_data[`WTB_SHAPE_MSB:`WTB_SHAPE_LSB]});
		end
	end

	always_comb begin
		pair_exchange_live_ff = live_cfg.pair_exchange;
		output_inversion_live_ff = live_cfg.output_inversion;
		circular_compare_live_ff = live_cfg.circular_compare;
		circular_top_live_ff = live_cfg.circular_top;
		ramp_live_ff = live_cfg.ramp;
		shape_select_live_ff = live_cfg.shape_select;
	end

	// Event pulse and DMA request both mark an applied update
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			update_event_ff <= 1'b0;
		end else begin
			update_event_ff <= apply_update;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			dma_req_ff <= 1'b0;
		end else if (apply_update) begin
			dma_req_ff <= 1'b1;
		end else if (dma_ack) begin
			dma_req_ff <= 1'b0;
		end
	end

	// Polarity acts per channel; only the first four channels have a
	// polarity bit, the rest pass through uninverted.
	genvar gi;
	generate
		for (gi = 0; gi < WO_NUM; gi++) begin : g_out
			if (gi < 4) begin : g_pol
				assign level_with_pol[gi] = compare_level[gi] ^ live_cfg.output_inversion[gi];
			end else begin : g_nopol
				assign level_with_pol[gi] = compare_level[gi];
			end
			if (gi < HALF && gi < 4) begin : g_lo
				assign nxt_wave[gi] = live_cfg.pair_exchange[gi] ?
					level_with_pol[gi + HALF] : level_with_pol[gi];
			end else if (gi >= HALF && (gi - HALF) < 4) begin : g_hi
				assign nxt_wave[gi] = live_cfg.pair_exchange[gi - HALF] ?
					level_with_pol[gi - HALF] : level_with_pol[gi];
			end else begin : g_plain
				assign nxt_wave[gi] = level_with_pol[gi];
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			waveform_out_ff <= '0;
		end else begin
			waveform_out_ff <= nxt_wave;
		end
	end

endmodule : wtb_waveform_buffer

//--- tb/wtb_waveform_buffer_monitor.sv
// Port-level checker for the waveform buffer block
`timescale 1ns/1ps
module wtb_waveform_buffer_monitor (
	input logic ref_clk,
	input logic rst_b,
	input logic bus_sel,
	input logic bus_write,
	input logic bus_read,
	input logic [31:0] bus_rdata_ff,
	input logic bus_ready_ff,
	input logic bus_error_ff,
	input logic double_buffer_en,
	input logic update_cond,
	input logic dma_ack,
	input logic dma_req_ff,
	input logic update_event_ff,
	input logic staged_valid_ff,
	input logic [3:0] pair_exchange_live_ff,
	input logic [3:0] output_inversion_live_ff,
	input logic [3:0] circular_compare_live_ff,
	input logic circular_top_live_ff,
	input logic [1:0] ramp_live_ff,
	input logic [2:0] shape_select_live_ff
);
	logic upd_go;
	logic [17:0] live;
	assign upd_go = double_buffer_en && update_cond && staged_valid_ff;
	assign live = {pair_exchange_live_ff, output_inversion_live_ff, circular_compare_live_ff,
		circular_top_live_ff, ramp_live_ff, shape_select_live_ff};
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	ready_one_cycle_a: assert property (bus_ready_ff |=> !bus_ready_ff)
		else $error("ready held longer than one cycle");
	read_answered_a: assert property (bus_sel && bus_read && !bus_write && !bus_ready_ff
		|=> bus_ready_ff)
		else $error("read not answered next cycle");
	error_with_ready_a: assert property (bus_error_ff |-> bus_ready_ff && bus_rdata_ff == 32'h0)
		else $error("error without ready or with data");
	update_applied_a: assert property (upd_go |=> update_event_ff && dma_req_ff)
		else $error("update condition not applied");
	live_held_a: assert property ($past(double_buffer_en) && double_buffer_en && !update_event_ff
		|-> $stable(live))
		else $error("live fields changed without update");
	event_pulse_a: assert property (update_event_ff && !$past(upd_go) |-> 1'b0)
		else $error("update event without cause");
	single_buffer_a: assert property (!double_buffer_en [*2] |-> !staged_valid_ff)
		else $error("staged content pending without buffering");
	dma_cleared_a: assert property (dma_ack && !upd_go |=> !dma_req_ff)
		else $error("dma request survived acknowledge");
	cover property (update_event_ff);
	cover property (bus_error_ff);
	cover property (dma_ack && dma_req_ff);
endmodule : wtb_waveform_buffer_monitor

//--- tb/wtb_pin_load.sv
// Load on the waveform pins: keeps the level each pin showed
`timescale 1ns/1ps
module wtb_pin_load #(
	parameter int WO_NUM = 8
) (
	input logic ref_clk,
	input logic [WO_NUM-1:0] pins,
	output logic [WO_NUM-1:0] seen_ff
);
	// Push-pull outputs, so the load only samples them
	always_ff @(posedge ref_clk) begin
		seen_ff <= pins;
	end
endmodule : wtb_pin_load

//--- tb/wtb_waveform_buffer_test.sv
// Self-checking bench for the waveform buffer block
`timescale 1ns/1ps
`include "wtb_defs.svh"
module wtb_waveform_buffer_test;
	localparam int WO_NUM = 8;
	localparam int POS [5] = '{0, 1, 2, 3, 11};
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic bus_sel = 1'b0;
	logic bus_write = 1'b0;
	logic bus_read = 1'b0;
	logic [7:0] bus_addr = 8'h00;
	logic [31:0] bus_wdata = 32'h0;
	logic [31:0] bus_rdata_ff;
	logic bus_ready_ff, bus_error_ff, irq_req_ff, dma_req_ff;
	logic update_event_ff, staged_valid_ff, sync_busy_ff;
	logic double_buffer_en = 1'b0;
	logic update_cond = 1'b0;
	logic dma_ack = 1'b0;
	logic [4:0] irq_events = 5'h00;
	logic [WO_NUM-1:0] compare_level = 8'h00;
	logic [WO_NUM-1:0] waveform_out_ff, seen;
	logic [3:0] pair_exchange_live_ff, output_inversion_live_ff, circular_compare_live_ff;
	logic circular_top_live_ff;
	logic [1:0] ramp_live_ff;
	logic [2:0] shape_select_live_ff;
	logic [17:0] live, old;
	logic [31:0] q, w, en;
	logic e;
	int err_count = 0;
	int compares = 0;
	int n;
	assign live = {pair_exchange_live_ff, output_inversion_live_ff, circular_compare_live_ff,
		circular_top_live_ff, ramp_live_ff, shape_select_live_ff};
	always #2 ref_clk = ~ref_clk;
	wtb_waveform_buffer #(.WO_NUM(WO_NUM), .SYNC_STAGES(1)) dut_u (.ref_clk, .rst_b, .bus_sel,
		.bus_write, .bus_read, .bus_addr, .bus_wdata, .bus_rdata_ff, .bus_ready_ff,
		.bus_error_ff, .double_buffer_en, .update_cond, .irq_events, .compare_level, .dma_ack,
		.waveform_out_ff, .irq_req_ff, .dma_req_ff, .update_event_ff, .staged_valid_ff,
		.sync_busy_ff, .pair_exchange_live_ff, .output_inversion_live_ff,
		.circular_compare_live_ff, .circular_top_live_ff, .ramp_live_ff, .shape_select_live_ff);
	wtb_pin_load #(.WO_NUM(WO_NUM)) load_u (.ref_clk, .pins(waveform_out_ff), .seen_ff(seen));
	function automatic logic [17:0] live_of(input logic [31:0] v);
		return {v[27:24], v[19:16], v[11:8], v[7], v[5:4], v[2:0]};
	endfunction : live_of
	// Pin view: polarity on channels 0..3, then channel x swapped with x+4
	function automatic logic [7:0] exp_wave(input logic [7:0] lv, input logic [3:0] pol,
		input logic [3:0] swp);
		logic [7:0] p;
		p = lv ^ {4'h0, pol};
		for (int i = 0; i < 4; i++) begin
			exp_wave[i] = swp[i] ? p[i + 4] : p[i];
			exp_wave[i + 4] = swp[i] ? p[i] : p[i + 4];
		end
	endfunction : exp_wave
	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask : tick
	task automatic print_verdict();
		$display("compares %0d, errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	// Called at one delay after an edge; the request holds until ready is seen
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		bus_sel = 1'b1;
		bus_write = wr;
		bus_read = !wr;
		bus_addr = a;
		bus_wdata = d;
		k = 0;
		do begin
			@(negedge ref_clk);
			k++;
		end while (bus_ready_ff !== 1'b1 && k < 20);
		if (k >= 20) begin
			chk(32'h0, 32'h1);
			print_verdict();
		end
		q = bus_rdata_ff;
		e = bus_error_ff;
		tick();
		bus_sel = 1'b0;
		bus_write = 1'b0;
		bus_read = 1'b0;
		// Let an edge pass so a following call never re-raises select in the same step
		tick();
	endtask : bus
	// Waits out a staged write still crossing into the core domain
	task automatic settle();
		for (n = 0; n < 20 && sync_busy_ff !== 1'b0; n++) tick();
		if (n == 20) begin
			chk(32'h0, 32'h1);
			print_verdict();
		end
		repeat (3) tick();
	endtask : settle
	initial begin
		void'($urandom(62));
		repeat (2) @(posedge ref_clk);
		#1 rst_b = 1'b1;
		bus(1'b0, `WTB_OFS_STAGED, 32'h0);
		chk(q, `WTB_STAGED_RESET);
		bus(1'b0, `WTB_OFS_IRQ_CLR, 32'h0);
		chk(q, `WTB_IRQ_RESET);
		bus(1'b0, 8'h40, 32'h0);
		chk({31'h0, e}, 32'h1);
		chk(q, 32'h0);
		repeat (4) begin
			compare_level = WO_NUM'($urandom);
			tick();
			chk(waveform_out_ff, compare_level);
			tick();
			chk(seen, compare_level);
		end
		en = 32'h0;
		for (int k = 0; k < 6; k++) begin
			w = (k == 0) ? 32'hFFFFFFFF : $urandom;
			bus(1'b1, `WTB_OFS_IRQ_SET, w);
			en = en | (w & `WTB_IRQ_MASK);
			bus(1'b0, `WTB_OFS_IRQ_CLR, 32'h0);
			chk(q, en);
			w = (k == 0) ? 32'h0 : $urandom;
			bus(1'b1, `WTB_OFS_IRQ_CLR, w);
			en = en & ~w;
			bus(1'b0, `WTB_OFS_IRQ_SET, 32'h0);
			chk(q, en);
			for (int i = 0; i < 5; i++) begin
				irq_events = 5'h01 << i;
				repeat (2) tick();
				chk(irq_req_ff, en[POS[i]]);
			end
			irq_events = 5'h00;
		end
		double_buffer_en = 1'b1;
		old = 18'h0;
		for (int k = 0; k < 4; k++) begin
			w = (k == 0) ? 32'hFFFFFFFF : $urandom;
			bus(1'b1, `WTB_OFS_STAGED, ~w);
			bus(1'b1, `WTB_OFS_STAGED, w);
			bus(1'b0, `WTB_OFS_STAGED, 32'h0);
			chk(q, w & `WTB_STAGED_MASK);
			settle();
			chk({staged_valid_ff, live}, {1'b1, old});
			update_cond = 1'b1;
			tick();
			update_cond = 1'b0;
			chk(live, live_of(w));
			chk({update_event_ff, dma_req_ff}, 2'h3);
			dma_ack = 1'b1;
			tick();
			dma_ack = 1'b0;
			tick();
			chk({staged_valid_ff, dma_req_ff}, 2'h0);
			old = live_of(w);
			// Nothing valid is staged now, so an update must copy nothing
			update_cond = 1'b1;
			tick();
			update_cond = 1'b0;
			chk({update_event_ff, live}, {1'b0, old});
		end
		double_buffer_en = 1'b0;
		w = $urandom;
		bus(1'b1, `WTB_OFS_STAGED, w);
		settle();
		chk({staged_valid_ff, live}, {1'b0, live_of(w)});
		repeat (4) begin
			compare_level = WO_NUM'($urandom);
			tick();
			chk(waveform_out_ff, exp_wave(compare_level, w[19:16], w[27:24]));
		end
		print_verdict();
	end
endmodule : wtb_waveform_buffer_test
bind wtb_waveform_buffer wtb_waveform_buffer_monitor mon_u (.ref_clk, .rst_b, .bus_sel,
	.bus_write, .bus_read, .bus_rdata_ff, .bus_ready_ff, .bus_error_ff, .double_buffer_en,
	.update_cond, .dma_ack, .dma_req_ff, .update_event_ff, .staged_valid_ff,
	.pair_exchange_live_ff, .output_inversion_live_ff, .circular_compare_live_ff,
	.circular_top_live_ff, .ramp_live_ff, .shape_select_live_ff);
